// File: logic/adaptive_clock_gen_regs.sv
/*
 * adaptive clock generator registers: two frequency words that drive
 * phase-accumulator synthesizers, a codec master clock output with a
 * selectable source, and a sof-captured 16-bit master clock counter.
 * assumes all inputs synchronous to sys_clk; master clocks are made
 * as phase-accumulator msbs, so every rising edge is seen as an enable pulse.
 */
`timescale 1ns/1ps

// Function
// - synth one word: three bytes, 23:0
// - synth one word programs its synthesizer
// - synth two may source the codec clock
// - free 16-bit counter captured at sof
// - counter clock selects between both outputs
// - capture read as two bytes, reset zero
// - synth two word: three bytes, same order
module adaptive_clock_gen_regs
    import acg_regs_pkg::*;
(
    input  wire logic              sys_clk,                 // 20 MHz clock
    input  wire logic              rst,                     // async, active high
    input  wire mcu_req_t          mcuReq,                  // mcu register access
    input  wire logic              sofPulse,                // usb start of frame
    input  wire logic              codecSourceSelTwo,       // 1: synth two feeds codec
    input  wire logic              captureSourceSelTwo,     // 1: count output two
    output logic [DATA_W-1:0]      rdData,                  // read data, one cycle later
    output logic                   rdValid,                 // read data valid pulse
    output logic                   codecMasterClockOut,     // codec master clock
    output logic                   codecMasterClockOutTwo,  // second master clock
    output logic [CAP_W-1:0]       mclkCaptureCount         // captured count
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // maps an offset to a frequency byte slot, 0..2 synth one, 3..5 two
    function automatic logic [2:0] freqSlot(input logic [15:0] a);
        case (a)
            SYNTH_ONE_FREQ_BYTE0_OFS: freqSlot = 3'h0;
            SYNTH_ONE_FREQ_BYTE1_OFS: freqSlot = 3'h1;
            SYNTH_ONE_FREQ_BYTE2_OFS: freqSlot = 3'h2;
            SYNTH_TWO_FREQ_BYTE0_OFS: freqSlot = 3'h3;
            SYNTH_TWO_FREQ_BYTE1_OFS: freqSlot = 3'h4;
            SYNTH_TWO_FREQ_BYTE2_OFS: freqSlot = 3'h5;
            default:                  freqSlot = 3'h7;
        endcase
    endfunction : freqSlot

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        freqByte_q [FREQ_BYTES];  // frequency byte registers
    logic [FREQ_W-1:0] freqWord [2];             // assembled words
    logic [FREQ_W-1:0] acc_q [2];                // phase accumulators
    logic [1:0]        synthMsb_q;               // synthesizer outputs
    logic [CAP_W-1:0]  counter_q;                // free-running count
    logic [CAP_W-1:0]  capture_q;                // captured count
    logic              capSrcPrev_q;             // previous counted level
    logic              capSrcNow;                // counted level now
    logic              capTick;                  // rising edge of counted clock
    logic [2:0]        wrSlot;                   // decoded write slot
    logic [2:0]        rdSlot;                   // decoded read slot
    logic [DATA_W-1:0] rdData_q;                 // read data flop
    logic              rdValid_q;                // read valid flop
    logic              codecOut_q;               // codec clock flop
    logic              codecOutTwo_q;            // second clock flop

    // write and read share one decode; rd and wr never come together
    assign wrSlot = freqSlot(mcuReq.addr);
    assign rdSlot = freqSlot(mcuReq.addr);

    // ------------------------------------------------------------
    // frequency byte registers and synthesizers
    // ------------------------------------------------------------
    for (genvar s = 0; s < 2; s++) begin : g_synth
        for (genvar b = 0; b < 3; b++) begin : g_byte
            // mcu write of one byte, reset zero
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    freqByte_q[s*3+b] <= FREQ_BYTE_RST;
                end else if (mcuReq.wr && wrSlot == 3'(s*3+b)) begin
                    freqByte_q[s*3+b] <= mcuReq.data;
                end
            end
        end

        // byte 2 high, byte 0 low
        assign freqWord[s] = {freqByte_q[s*3+2], freqByte_q[s*3+1], freqByte_q[s*3]};

        // phase accumulator; its msb is the synthesized clock
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                acc_q[s]      <= ACC_RST;
                synthMsb_q[s] <= 1'b0;
            end else begin
                acc_q[s]      <= acc_q[s] + freqWord[s];
                synthMsb_q[s] <= acc_q[s][FREQ_W-1];
            end
        end
    end

    // ------------------------------------------------------------
    // master clock outputs
    // ------------------------------------------------------------

    // codec clock from either synthesizer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            codecOut_q    <= 1'b0;
            codecOutTwo_q <= 1'b0;
        end else begin
            codecOut_q    <= codecSourceSelTwo ? synthMsb_q[1] : synthMsb_q[0];
            codecOutTwo_q <= synthMsb_q[1];
        end
    end

    // ------------------------------------------------------------
    // capture counter
    // ------------------------------------------------------------
    // counted clock taken from the output flops, so ticks lag one cycle
    assign capSrcNow = captureSourceSelTwo ? codecOutTwo_q : codecOut_q;
    assign capTick   = capSrcNow & ~capSrcPrev_q;

    // edge detect of the counted clock
    // reset level matches the idle low clock, so no false tick
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            capSrcPrev_q <= 1'b0;
        end else begin
            capSrcPrev_q <= capSrcNow;
        end
    end

    // free-running count, wraps past all ones
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            counter_q <= COUNTER_RST;
        end else if (capTick) begin
            counter_q <= counter_q + 16'h0001;
        end
    end

    // snapshot at each start of frame
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            capture_q <= CAPTURE_RST;
        end else if (sofPulse) begin
            capture_q <= counter_q;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------

    // registered read mux, unmapped reads zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData_q  <= RDATA_RST;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= mcuReq.rd;
            if (!mcuReq.rd) begin
                rdData_q <= RDATA_RST;
            end else if (mcuReq.addr == MCLK_CAPTURE_LOW_OFS) begin
                rdData_q <= capture_q[7:0];
            end else if (mcuReq.addr == MCLK_CAPTURE_HIGH_OFS) begin
                rdData_q <= capture_q[15:8];
            end else if (rdSlot < 3'(FREQ_BYTES)) begin
                rdData_q <= freqByte_q[rdSlot];
            end else begin
                rdData_q <= RDATA_RST;
            end
        end
    end

    // every output comes straight from its flop
    assign rdData                 = rdData_q;
    assign rdValid                = rdValid_q;
    assign codecMasterClockOut    = codecOut_q;
    assign codecMasterClockOutTwo = codecOutTwo_q;
    assign mclkCaptureCount       = capture_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // byte 0 write lands in the low end of word one
    one_low_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.wr && mcuReq.addr == SYNTH_ONE_FREQ_BYTE0_OFS
        |=> freqWord[0][7:0] == $past(mcuReq.data))
        else $error("synth one byte 0 not written");

    // byte 2 write touches only the top of word one
    one_high_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.wr && mcuReq.addr == SYNTH_ONE_FREQ_BYTE2_OFS
        |=> freqWord[0][23:16] == $past(mcuReq.data) && $stable(freqWord[0][15:0]))
        else $error("synth one byte 2 write wrong");

    // synth two byte 1 write leaves word one alone
    two_mid_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.wr && mcuReq.addr == SYNTH_TWO_FREQ_BYTE1_OFS
        |=> freqWord[1][15:8] == $past(mcuReq.data) && $stable(freqWord[0]))
        else $error("synth two byte 1 write wrong");

    // synth one accumulator steps by its word every cycle
    synth_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 acc_q[0] == 24'($past(acc_q[0]) + $past(freqWord[0])))
        else $error("synth one accumulator misstep");

    // synth two feeds the codec clock while selected for two cycles
    codec_source_a: assert property (@(posedge sys_clk) disable iff (rst)
        codecSourceSelTwo ##1 codecSourceSelTwo
        |=> codecOut_q == $past(acc_q[1][FREQ_W-1], 2))
        else $error("codec clock not from synth two");

    // a rise of the second output bumps the counter
    count_select_a: assert property (@(posedge sys_clk) disable iff (rst)
        captureSourceSelTwo && codecOutTwo_q && !capSrcPrev_q
        |=> counter_q == 16'($past(counter_q) + 16'h0001))
        else $error("counter missed second clock edge");

    // sof snapshots the pre-increment count
    sof_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        sofPulse |=> mclkCaptureCount == $past(counter_q))
        else $error("capture not taken at sof");

    // high capture byte read returns bits 15:8
    capture_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.rd && mcuReq.addr == MCLK_CAPTURE_HIGH_OFS && !sofPulse
        |=> rdValid && rdData == capture_q[15:8])
        else $error("capture high byte read wrong");

    // the wrap takes 64k counted edges, longer than a short bench run
    // so this one is only reached in long system runs
    counter_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
        capTick && counter_q == 16'hffff |=> counter_q == 16'h0000)
        else $error("counter did not wrap");

    // synth two accumulator steps by its own word
    two_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 acc_q[1]
            == 24'($past(acc_q[1]) + $past(freqWord[1])))
        else $error("synth two accumulator misstep");

    // synth one feeds the codec clock while not deselected
    codec_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        !codecSourceSelTwo ##1 !codecSourceSelTwo
        |=> codecOut_q == $past(acc_q[0][FREQ_W-1], 2))
        else $error("codec clock not from synth one");

    // second output always follows synth two
    second_out_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##2 codecOutTwo_q
            == $past(acc_q[1][FREQ_W-1], 2))
        else $error("second clock not from synth two");

    // a rise of the first output bumps the counter
    count_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        !captureSourceSelTwo && codecOut_q && !capSrcPrev_q
        |=> counter_q == 16'($past(counter_q) + 16'h0001))
        else $error("counter missed first clock edge");

    // no counted edge, no count
    count_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !capTick
        |=> counter_q == $past(counter_q))
        else $error("counter moved without a clock edge");

    // captured value stands until the next sof
    capture_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !sofPulse
        |=> mclkCaptureCount == $past(mclkCaptureCount))
        else $error("capture changed without sof");

    // low capture byte read returns bits 7:0
    capture_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.rd && mcuReq.addr == MCLK_CAPTURE_LOW_OFS && !sofPulse
        |=> rdValid && rdData == capture_q[7:0])
        else $error("capture low byte read wrong");

    // writes outside the frequency bytes change nothing
    capture_ro_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.wr && wrSlot == 3'h7 && !sofPulse
        |=> $stable(capture_q) && $stable(freqWord[0]) && $stable(freqWord[1]))
        else $error("write outside the frequency bytes took effect");

    // the low byte of word one reads back as stored
    freq_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.rd && mcuReq.addr == SYNTH_ONE_FREQ_BYTE0_OFS
        |=> rdValid && rdData == $past(freqWord[0][7:0]))
        else $error("synth one byte 0 read wrong");

    // synth two byte 0 write lands low and leaves word one alone
    two_low_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcuReq.wr && mcuReq.addr == SYNTH_TWO_FREQ_BYTE0_OFS
        |=> freqWord[1][7:0] == $past(mcuReq.data) && $stable(freqWord[0]))
        else $error("synth two byte 0 write wrong");

endmodule : adaptive_clock_gen_regs

// File: logic/acg_regs_pkg.sv
/*
 * package for the adaptive clock generator register block: register
 * offsets, reset values, widths and the mcu access carrier.
 * assumes an 8-bit mcu data path on a 16-bit memory address.
 */
package acg_regs_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W     = 16;   // mcu address width
    localparam int unsigned DATA_W     = 8;    // mcu data width
    localparam int unsigned FREQ_W     = 24;   // frequency word width
    localparam int unsigned CAP_W      = 16;   // capture counter width
    localparam int unsigned FREQ_BYTES = 6;    // two synths, three bytes each

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] MCLK_CAPTURE_HIGH_OFS    = 16'hffe3;
    localparam logic [15:0] MCLK_CAPTURE_LOW_OFS     = 16'hffe4;
    localparam logic [15:0] SYNTH_ONE_FREQ_BYTE2_OFS = 16'hffe5;
    localparam logic [15:0] SYNTH_ONE_FREQ_BYTE1_OFS = 16'hffe6;
    localparam logic [15:0] SYNTH_ONE_FREQ_BYTE0_OFS = 16'hffe7;
    localparam logic [15:0] SYNTH_TWO_FREQ_BYTE2_OFS = 16'hfff7;
    localparam logic [15:0] SYNTH_TWO_FREQ_BYTE1_OFS = 16'hfff8;
    localparam logic [15:0] SYNTH_TWO_FREQ_BYTE0_OFS = 16'hfff9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  FREQ_BYTE_RST = 8'h00;   // frequency bytes
    localparam logic [15:0] CAPTURE_RST   = 16'h0000; // captured count
    localparam logic [15:0] COUNTER_RST   = 16'h0000; // free-running count
    localparam logic [23:0] ACC_RST       = 24'h000000; // phase accumulators
    localparam logic [7:0]  RDATA_RST     = 8'h00;   // read data / unmapped

    // ------------------------------------------------------------
    // mcu access carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;     // write strobe, one cycle
        logic        rd;     // read strobe, one cycle
        logic [15:0] addr;   // byte address
        logic [7:0]  data;   // write data
    } mcu_req_t;

endpackage : acg_regs_pkg

// File: verif/codec_clock_sink.sv
/*
 * codec side model: counts rising edges of a master clock it receives.
 * assumes the clock comes from the device, already aligned to sys_clk.
 */
`timescale 1ns/1ps

module codec_clock_sink (
    input  wire logic        sys_clk,  // sampling clock
    input  wire logic        clear,    // restart the count
    input  wire logic        mclk,     // master clock from the device
    output logic      [15:0] rises     // rising edges seen since clear
);
    logic mclkQ;  // previous sample of the clock

    // edge detect and count
    always_ff @(posedge sys_clk) begin
        mclkQ <= mclk;
        if (clear) begin
            rises <= 16'h0000;
        end else if (mclk && !mclkQ) begin
            rises <= rises + 16'h0001;
        end
    end
endmodule : codec_clock_sink

// File: verif/adaptive_clock_gen_regs_tb.sv
/*
 * testbench: register access, synthesizer rates, sof capture.
 * assumes the register block and its package; codec model counts edges.
 */
`timescale 1ns/1ps

module adaptive_clock_gen_regs_tb;
    import acg_regs_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        sys_clk, rst, sofPulse, codecSelTwo, captureSelTwo, clear;
    mcu_req_t    mcuReq;                       // register access
    logic [7:0]  rdData, d, lo, hi;            // read data
    logic        rdValid, mclkOne, mclkTwo;    // design outputs
    logic [15:0] capCount, risesOne, risesTwo, first;
    int          errorCnt, checked, cycles;
    logic [15:0] FOFS [6] = '{SYNTH_ONE_FREQ_BYTE2_OFS, SYNTH_ONE_FREQ_BYTE1_OFS,
        SYNTH_ONE_FREQ_BYTE0_OFS, SYNTH_TWO_FREQ_BYTE2_OFS, SYNTH_TWO_FREQ_BYTE1_OFS,
        SYNTH_TWO_FREQ_BYTE0_OFS};
    logic [7:0]  WORDS [6] = '{8'h40, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};

    adaptive_clock_gen_regs i_adaptive_clock_gen_regs (.sys_clk(sys_clk), .rst(rst),
        .mcuReq(mcuReq), .sofPulse(sofPulse), .codecSourceSelTwo(codecSelTwo),
        .captureSourceSelTwo(captureSelTwo), .rdData(rdData), .rdValid(rdValid),
        .codecMasterClockOut(mclkOne), .codecMasterClockOutTwo(mclkTwo),
        .mclkCaptureCount(capCount));
    codec_clock_sink i_codec_clock_sink (.sys_clk(sys_clk), .clear(clear), .mclk(mclkOne),
        .rises(risesOne));
    codec_clock_sink i_codec_clock_sink_two (.sys_clk(sys_clk), .clear(clear),
        .mclk(mclkTwo), .rises(risesTwo));

    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errorCnt++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        mcuReq <= {1'b1, 1'b0, a, v};
        @(posedge sys_clk);
        mcuReq.wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        int n;
        @(posedge sys_clk);
        mcuReq <= {1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        mcuReq.rd <= 1'b0;
        #1;
        n = 0;
        while (rdValid !== 1'b1 && n < 3) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("read valid", 16'h0001, {15'h0000, rdValid});
        v = rdData;
    endtask : rd_reg

    // counts both outputs over 64 cycles
    task automatic measure(input logic [15:0] expOne, input logic [15:0] expTwo);
        @(posedge sys_clk);
        clear <= 1'b1;
        @(posedge sys_clk);
        clear <= 1'b0;
        repeat (64) @(posedge sys_clk);
        #1;
        chk("rises one", expOne, risesOne);
        chk("rises two", expTwo, risesTwo);
    endtask : measure

    task automatic pulse_sof;
        @(posedge sys_clk);
        sofPulse <= 1'b1;
        @(posedge sys_clk);
        sofPulse <= 1'b0;
    endtask : pulse_sof

    task automatic stop_test;
        if (errorCnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; mcuReq = '0; sofPulse = 1'b0; clear = 1'b0;
        codecSelTwo = 1'b0; captureSelTwo = 1'b0; errorCnt = 0; checked = 0; cycles = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values and capture bytes
        foreach (FOFS[i]) begin
            rd_reg(FOFS[i], d); chk("freq reset", 16'h0000, {8'h00, d});
        end
        rd_reg(MCLK_CAPTURE_LOW_OFS, d); chk("cap low reset", 16'h0000, {8'h00, d});
        rd_reg(MCLK_CAPTURE_HIGH_OFS, d); chk("cap high reset", 16'h0000, {8'h00, d});
        rd_reg(16'hffe0, d); chk("unmapped read", 16'h0000, {8'h00, d});
        measure(16'h0000, 16'h0000);
        // distinct readback, then capture writes ignored
        foreach (FOFS[i]) wr_reg(FOFS[i], 8'h5a + 8'(i * 17));
        foreach (FOFS[i]) begin
            rd_reg(FOFS[i], d); chk("freq byte", {8'h00, 8'h5a + 8'(i * 17)}, {8'h00, d});
        end
        wr_reg(MCLK_CAPTURE_LOW_OFS, 8'hff);
        rd_reg(MCLK_CAPTURE_LOW_OFS, d); chk("cap read only", 16'h0000, {8'h00, d});
        // synth one 400000h, synth two 200000h: periods 4 and 8 cycles
        foreach (FOFS[i]) wr_reg(FOFS[i], WORDS[i]);
        measure(16'h0010, 16'h0008);
        codecSelTwo <= 1'b1;
        measure(16'h0008, 16'h0008);
        codecSelTwo <= 1'b0;
        // capture over 64 cycles from either output
        for (int s = 0; s < 2; s++) begin
            captureSelTwo <= s[0];
            repeat (4) @(posedge sys_clk);
            pulse_sof();
            #1;
            first = capCount;
            repeat (62) @(posedge sys_clk);
            pulse_sof();
            #1;
            chk("capture delta", first + (16'h0010 >> s), capCount);
            rd_reg(MCLK_CAPTURE_LOW_OFS, lo);
            rd_reg(MCLK_CAPTURE_HIGH_OFS, hi);
            chk("capture bytes", capCount, {hi, lo});
        end
        // reset in mid-run clears the words, the capture and the clocks
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd_reg(SYNTH_ONE_FREQ_BYTE2_OFS, d); chk("freq after reset", 16'h0000, {8'h00, d});
        rd_reg(SYNTH_TWO_FREQ_BYTE2_OFS, d); chk("two after reset", 16'h0000, {8'h00, d});
        rd_reg(MCLK_CAPTURE_LOW_OFS, d); chk("cap after reset", 16'h0000, {8'h00, d});
        measure(16'h0000, 16'h0000);
        stop_test();
    end
endmodule : adaptive_clock_gen_regs_tb
